// file: core/ops_panel_sequencer.sv
/*
 Operator panel sequencer: function gates over the instruction pair,
 manual and automatic stepping, breakpoint stops and the tape load.
 Assumes memory answers a read with mem_rd_valid some cycles later,
 instruction control answers each execute request with ctl.done, and
 the tape reader presents one delivery per valid cycle during load.
*/
module ops_panel_sequencer
	import ops_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [SW_COUNT-1:0] panel_sw,
	input wire logic [ADDR_W-1:0] counter_switches,
	input wire ops_tape_type tape_in,
	input wire logic mem_rd_valid,
	input wire logic [WORD_W-1:0] mem_rd_data,
	input wire ops_ctl_type ctl_in,
	input wire logic operand_wr_en,
	input wire logic [WORD_W-1:0] operand_wr_data,
	output ops_mem_type mem_out,
	output ops_exec_type exec_out,
	output logic gate_left_reg,
	output logic gate_right_reg,
	output logic [ADDR_W-1:0] counter_reg,
	output logic [WORD_W-1:0] instruction_pair_register,
	output logic [WORD_W-1:0] reader_word_register,
	output logic [WORD_W-1:0] load_checksum_accumulator,
	output logic [WORD_W-1:0] preserved_operand_register,
	output logic bp_halt_reg,
	output logic running_reg
);

	ops_state_type state_reg;
	ops_state_type state_next;
	logic [SW_COUNT-1:0] sw_level;
	logic [SW_COUNT-1:0] sw_rise;
	logic [ADDR_W-1:0] load_start_reg;
	logic [1:0] space_cnt_reg;
	logic pair_empty_reg;
	logic xfer_pend_reg;
	logic xfer_right_reg;
	logic [HALF_W-1:0] connected;
	logic bp_hit;
	logic halted_cmd;
	logic start_ok;
	logic perform_ok;
	logic auto_next;
	logic go_fetch;
	logic go_right;
	logic fetch_done;
	logic tape_word;
	logic tape_space;
	logic load_end;
	logic exec_done;

	// Every press passes the synchroniser before any use
	ops_switch_sync #(.N(SW_COUNT)) u_sync (
		.clock(clock),
		.rst(rst),
		.sw_raw(panel_sw),
		.sw_level(sw_level),
		.sw_rise(sw_rise)
	);

	assign connected = gate_right_reg ? instruction_pair_register[HALF_W-1:0]
		: instruction_pair_register[WORD_W-1:HALF_W];

	assign bp_hit = (sw_level[SW_RED] && !connected[RED_BIT_POS])
		|| (sw_level[SW_GREEN] && !connected[GREEN_BIT_POS]);

	assign halted_cmd = (state_reg == S_HALT) && !sw_level[SW_LOAD];
	assign start_ok = halted_cmd && sw_rise[SW_START];
	assign perform_ok = halted_cmd && sw_rise[SW_PERFORM] && !start_ok;
	assign exec_done = (state_reg == S_EXEC_WAIT) && ctl_in.done;
	assign auto_next = exec_done && sw_level[SW_AUTO];

	// left to right step, right side fetches next word
	assign go_fetch = (start_ok && (gate_right_reg || xfer_pend_reg))
		|| (auto_next && (gate_right_reg || ctl_in.xfer));
	assign go_right = (start_ok && !gate_right_reg && !xfer_pend_reg)
		|| (auto_next && !gate_right_reg && !ctl_in.xfer);
	assign fetch_done = (state_reg == S_FETCH_WAIT) && mem_rd_valid;

	// Tape deliveries are only looked at while waiting for the reader
	assign tape_word = (state_reg == S_LOAD_WAIT) && tape_in.valid && !tape_in.is_space;
	assign tape_space = (state_reg == S_LOAD_WAIT) && tape_in.valid && tape_in.is_space;
	assign load_end = tape_space && (space_cnt_reg == 2'(SPACE_END_COUNT - 1));

	// Next state of the sequencer
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			S_HALT:
			begin
				if (sw_level[SW_LOAD])
					state_next = S_LOAD_WAIT;
				else if (go_fetch)
					state_next = S_FETCH;
				else if (go_right && !pair_empty_reg)
					state_next = S_CONNECT;
				else if (perform_ok)
					state_next = S_EXEC;
			end
			S_FETCH:
				state_next = S_FETCH_WAIT;
			S_FETCH_WAIT:
			begin
				if (mem_rd_valid)
					state_next = S_CONNECT;
			end
			S_CONNECT:
			begin
				if (bp_hit)
					state_next = S_HALT;
				else
					state_next = S_EXEC;
			end
			S_EXEC:
				state_next = S_EXEC_WAIT;
			S_EXEC_WAIT:
			begin
				if (ctl_in.done)
				begin
					if (go_fetch)
						state_next = S_FETCH;
					else if (go_right)
						state_next = S_CONNECT;
					else
						state_next = S_HALT;
				end
			end
			S_LOAD_WAIT:
			begin
				if (load_end)
					state_next = S_LOAD_DONE;
				else if (tape_word)
					state_next = S_LOAD_WRITE;
			end
			S_LOAD_WRITE:
				state_next = S_LOAD_WAIT;
			S_LOAD_DONE:
			begin
				// wait for operator to drop load
				if (!sw_level[SW_LOAD])
					state_next = S_HALT;
			end
		endcase
	end

	// State register and run indicator
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= S_HALT;
			running_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			running_reg <= (state_next != S_HALT) && (state_next != S_LOAD_DONE);
		end
	end

	// Function gates; right after reset so the first start fetches
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			gate_left_reg <= 1'b0;
			gate_right_reg <= 1'b1;
		end
		else if (fetch_done)
		begin
			gate_left_reg <= !xfer_pend_reg || !xfer_right_reg;
			gate_right_reg <= xfer_pend_reg && xfer_right_reg;
		end
		else if (go_right && (state_reg == S_HALT || state_reg == S_EXEC_WAIT))
		begin
			gate_left_reg <= 1'b0;
			gate_right_reg <= 1'b1;
		end
	end

	// Pending transfer; applied at the next fetch
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			xfer_pend_reg <= 1'b0;
			xfer_right_reg <= 1'b0;
		end
		else if (exec_done && ctl_in.xfer)
		begin
			xfer_pend_reg <= 1'b1;
			xfer_right_reg <= ctl_in.xfer_right;
		end
		else if (fetch_done)
			xfer_pend_reg <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			counter_reg <= COUNTER_RESET;
		else if (load_end)
			counter_reg <= load_start_reg;
		else if (state_reg == S_LOAD_WRITE || fetch_done)
			// advance by one, next load slot or next pair
			counter_reg <= counter_reg + ADDR_W'(ADDR_STEP);
		else if (exec_done && ctl_in.xfer)
			counter_reg <= ctl_in.xfer_addr;
		else if (halted_cmd && sw_rise[SW_SETCTR])
			counter_reg <= counter_switches;
	end

	// Start address remembered for the restore
	always_ff @(posedge clock)
	begin
		if (rst)
			load_start_reg <= COUNTER_RESET;
		else if (state_reg == S_HALT && sw_level[SW_LOAD])
			load_start_reg <= counter_reg;
	end

	// Adjacent space counter; any word breaks the run
	always_ff @(posedge clock)
	begin
		if (rst)
			space_cnt_reg <= 2'h0;
		else if (state_reg != S_LOAD_WAIT || tape_word)
			space_cnt_reg <= 2'h0;
		else if (tape_space)
			space_cnt_reg <= space_cnt_reg + 2'h1;
	end

	// Instruction pair; stays zero for the whole load
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			instruction_pair_register <= 40'h00_0000_0000;
			pair_empty_reg <= 1'b0;
		end
		else if (state_reg == S_HALT && sw_level[SW_LOAD])
		begin
			instruction_pair_register <= 40'h00_0000_0000;
			pair_empty_reg <= 1'b1;
		end
		else if (fetch_done)
		begin
			instruction_pair_register <= mem_rd_data;
			pair_empty_reg <= 1'b0;
		end
	end

	// Reader word and checksum during load
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			reader_word_register <= 40'h00_0000_0000;
			load_checksum_accumulator <= 40'h00_0000_0000;
		end
		else if (state_reg == S_HALT && sw_level[SW_LOAD])
		begin
			reader_word_register <= 40'h00_0000_0000;
			load_checksum_accumulator <= 40'h00_0000_0000;
		end
		else if (tape_word)
		begin
			// capture word first, last word stays
			reader_word_register <= tape_in.word;
			load_checksum_accumulator <= load_checksum_accumulator + tape_in.word;
		end
	end

	// Operand register belongs to arithmetic; loading never writes it
	always_ff @(posedge clock)
	begin
		if (rst)
			preserved_operand_register <= 40'h00_0000_0000;
		else if (operand_wr_en && state_reg != S_LOAD_WAIT && state_reg != S_LOAD_WRITE)
			preserved_operand_register <= operand_wr_data;
	end

	// Memory requests: one-cycle strobes, address held between them
	always_ff @(posedge clock)
	begin
		if (rst)
			mem_out <= '0;
		else
		begin
			mem_out.rd_req <= (state_reg == S_FETCH);
			// write at counter, from reader word
			mem_out.wr_en <= (state_reg == S_LOAD_WRITE);
			if (state_reg == S_FETCH || state_reg == S_LOAD_WRITE)
				mem_out.addr <= counter_reg;
			if (state_reg == S_LOAD_WRITE)
				mem_out.wr_data <= reader_word_register;
		end
	end

	// Execute request; in manual mode gates stay on the executed half afterwards
	always_ff @(posedge clock)
	begin
		if (rst)
			exec_out <= '0;
		else
		begin
			exec_out.req <= (state_reg == S_EXEC);
			if (state_reg == S_EXEC)
				exec_out.instr <= connected;
		end
	end

	// Breakpoint stop flag; a start then moves past the instruction
	always_ff @(posedge clock)
	begin
		if (rst)
			bp_halt_reg <= 1'b0;
		else if (state_reg == S_CONNECT && bp_hit)
			bp_halt_reg <= 1'b1;
		else if (state_reg == S_HALT && (start_ok || perform_ok || sw_level[SW_LOAD]))
			bp_halt_reg <= 1'b0;
	end

	AST_GATE_ONEHOT:
	assert property (@(posedge clock) disable iff (rst) gate_left_reg != gate_right_reg)
	else $error("function gates not one-hot");

	AST_LOAD_PAIR_ZERO:
	assert property (@(posedge clock) disable iff (rst)
		(state_reg == S_LOAD_WAIT || state_reg == S_LOAD_WRITE) |-> instruction_pair_register == '0)
	else $error("instruction pair not zero during load");

	AST_LOAD_WRITE:
	assert property (@(posedge clock) disable iff (rst)
		state_reg == S_LOAD_WRITE |=> mem_out.wr_en && mem_out.addr == $past(counter_reg)
		&& mem_out.wr_data == reader_word_register)
	else $error("load write wrong address or data");

	AST_CHECKSUM:
	assert property (@(posedge clock) disable iff (rst)
		tape_word |=> load_checksum_accumulator
		== $past(load_checksum_accumulator) + $past(tape_in.word))
	else $error("checksum did not accumulate");

	AST_LOAD_RESTORE:
	assert property (@(posedge clock) disable iff (rst)
		load_end |=> state_reg == S_LOAD_DONE && counter_reg == $past(load_start_reg))
	else $error("counter not restored after load");

	AST_NO_EXEC_LOAD:
	assert property (@(posedge clock) disable iff (rst)
		state_reg == S_LOAD_DONE && sw_level[SW_LOAD] |=> !exec_out.req && state_reg == S_LOAD_DONE)
	else $error("execution while load held");

	AST_MANUAL_HALT:
	assert property (@(posedge clock) disable iff (rst)
		exec_done && !sw_level[SW_AUTO] |=> state_reg == S_HALT ##1 !exec_out.req)
	else $error("manual mode did not halt");

	AST_RIGHT_STEP:
	assert property (@(posedge clock) disable iff (rst)
		start_ok && !gate_right_reg && !xfer_pend_reg && !pair_empty_reg
		|=> gate_right_reg && state_reg == S_CONNECT ##0 (bp_hit or (!bp_hit ##2 exec_out.req)))
	else $error("left start did not execute right half");

	AST_FETCH_INC:
	assert property (@(posedge clock) disable iff (rst)
		fetch_done |=> counter_reg == $past(counter_reg) + ADDR_W'(ADDR_STEP)
		&& instruction_pair_register == $past(mem_rd_data))
	else $error("fetch did not load pair and advance");

	AST_BP_HALT:
	assert property (@(posedge clock) disable iff (rst)
		state_reg == S_CONNECT && bp_hit |=> state_reg == S_HALT && $stable(gate_right_reg)
		&& bp_halt_reg)
	else $error("breakpoint did not stop");

	AST_BP_OFF:
	assert property (@(posedge clock) disable iff (rst)
		state_reg == S_CONNECT && !bp_hit |=> state_reg == S_EXEC ##1 exec_out.req)
	else $error("unmarked instruction not executed");

	AST_OPERAND_KEPT:
	assert property (@(posedge clock) disable iff (rst)
		state_reg == S_LOAD_WAIT |=> $stable(preserved_operand_register))
	else $error("operand changed during load");

endmodule

// file: core/ops_pkg.sv
/*
 Shared constants, carrier structs and the sequencer state type for the
 operator panel sequencer. Assumes a single 100 MHz clock domain and
 synchronous active-high reset in every user of this package.
*/
package ops_pkg;

	// Data and address sizes
	localparam int WORD_W = 40;
	localparam int HALF_W = 20;
	localparam int ADDR_W = 10;

	// Breakpoint marks inside one instruction: first and fifth order bits
	localparam int RED_BIT_POS = 19;
	localparam int GREEN_BIT_POS = 15;

	// Tape end marker length and counter step
	localparam int SPACE_END_COUNT = 2;
	localparam int ADDR_STEP = 1;
	localparam logic [ADDR_W-1:0] COUNTER_RESET = 10'h000;

	// Operator switch positions on the synchroniser bus
	localparam int SW_LOAD = 0;
	localparam int SW_START = 1;
	localparam int SW_PERFORM = 2;
	localparam int SW_SETCTR = 3;
	localparam int SW_RED = 4;
	localparam int SW_GREEN = 5;
	localparam int SW_AUTO = 6;
	localparam int SW_COUNT = 7;

	// One tape reader delivery: a word or a space character
	typedef struct packed {
		logic valid;
		logic is_space;
		logic [WORD_W-1:0] word;
	} ops_tape_type;

	// Memory request towards storage
	typedef struct packed {
		logic rd_req;
		logic wr_en;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wr_data;
	} ops_mem_type;

	// Execute request towards instruction control
	typedef struct packed {
		logic req;
		logic [HALF_W-1:0] instr;
	} ops_exec_type;

	// Completion report from instruction control
	typedef struct packed {
		logic done;
		logic xfer;
		logic xfer_right;
		logic [ADDR_W-1:0] xfer_addr;
	} ops_ctl_type;

	typedef enum logic [3:0] {
		S_HALT,
		S_FETCH,
		S_FETCH_WAIT,
		S_CONNECT,
		S_EXEC,
		S_EXEC_WAIT,
		S_LOAD_WAIT,
		S_LOAD_WRITE,
		S_LOAD_DONE
	} ops_state_type;

endpackage

// file: core/ops_switch_sync.sv
/*
 Synchroniser for the operator switches: a clean level and a one-cycle
 rising-edge pulse per switch. Assumes raw switches are debounced levels.
*/
module ops_switch_sync
	import ops_pkg::*;
#(
	parameter int N = SW_COUNT
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [N-1:0] sw_raw,
	output logic [N-1:0] sw_level,
	output logic [N-1:0] sw_rise
);

	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;
	logic [N-1:0] prev_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_sw
			always_ff @(posedge clock)
			begin
				if (rst)
				begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
					prev_reg[i] <= 1'b0;
					sw_rise[i] <= 1'b0;
				end
				else
				begin
					meta_reg[i] <= sw_raw[i];
					sync_reg[i] <= meta_reg[i];
					prev_reg[i] <= sync_reg[i];
					sw_rise[i] <= sync_reg[i] & ~prev_reg[i]; // Edge taken after sync only
				end
			end
		end
	endgenerate

	// Level follows the second stage, one flop later to stay registered
	assign sw_level = prev_reg;

endmodule

// file: tb/ops_far_model.sv
/*
 Far side model: memory and instruction control. The all-zero order is
 treated as a transfer to the right half of the word at XFER_TARGET.
 Assumes the sequencer drives one-cycle rd_req, wr_en and exec req
 pulses on a rising edge.
*/
module ops_far_model
	import ops_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire ops_mem_type mem_out,
	input wire ops_exec_type exec_out,
	output logic mem_rd_valid,
	output logic [WORD_W-1:0] mem_rd_data,
	output ops_ctl_type ctl_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [WORD_W-1:0] mem_reg [0:1023];
	logic [ADDR_W-1:0] rd_addr;
	int rd_wait = 0;
	int done_wait = 0;
	logic slow = 0;
	logic xfer_due = 0;
	// Transfer target; matches the bench's load start address
	localparam logic [ADDR_W-1:0] XFER_TARGET = 10'h3FE;

	// Memory starts cleared, as the operator clears it before a load
	initial
	begin
		foreach (mem_reg[i]) mem_reg[i] = '0;
		mem_rd_valid = 0;
		mem_rd_data = '0;
		ctl_in = '0;
	end

	// Read answers after three cycles; done alternates quick and slow
	always @(posedge clock)
	begin
		mem_rd_valid <= 1'b0;
		ctl_in.done <= 1'b0;
		ctl_in.xfer <= 1'b0;
		ctl_in.xfer_addr <= ~ctl_in.xfer_addr; // Idle field never holds still
		if (mem_rd_valid)
			mem_rd_data <= ~mem_rd_data; // Released data does not linger
		if (mem_out.wr_en)
			mem_reg[mem_out.addr] <= mem_out.wr_data;
		if (rst)
			rd_wait <= 0;
		else if (mem_out.rd_req)
		begin
			rd_wait <= 3;
			rd_addr <= mem_out.addr;
		end
		else if (rd_wait == 1)
		begin
			mem_rd_valid <= 1'b1;
			mem_rd_data <= mem_reg[rd_addr];
			rd_wait <= 0;
		end
		else if (rd_wait > 1)
			rd_wait <= rd_wait - 1;
		if (rst)
			done_wait <= 0;
		else if (exec_out.req)
		begin
			done_wait <= slow ? 6 : 1;
			slow <= !slow;
			xfer_due <= (exec_out.instr == '0);
		end
		else if (done_wait == 1)
		begin
			ctl_in.done <= 1'b1;
			// Transfer report travels with done; later assignment wins
			ctl_in.xfer <= xfer_due;
			ctl_in.xfer_right <= 1'b1;
			ctl_in.xfer_addr <= XFER_TARGET;
			done_wait <= 0;
		end
		else if (done_wait > 1)
			done_wait <= done_wait - 1;
	end
endmodule

// file: tb/ops_panel_sequencer_test.sv
/*
 Self-checking bench for the operator panel sequencer. Assumes the far
 side model answers memory reads and executions; the bench plays the
 operator and the tape reader, driving at the falling edge.
*/
module ops_panel_sequencer_test
	import ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic rst = 1;
	logic [SW_COUNT-1:0] panel_sw = '0;
	logic [ADDR_W-1:0] counter_switches = '0;
	ops_tape_type tape_in = '0;
	logic operand_wr_en = 0;
	logic [WORD_W-1:0] operand_wr_data = '0;
	logic mem_rd_valid;
	logic [WORD_W-1:0] mem_rd_data;
	ops_ctl_type ctl_in;
	ops_mem_type mem_out;
	ops_exec_type exec_out;
	logic gate_left_reg, gate_right_reg, bp_halt_reg, running_reg;
	logic [ADDR_W-1:0] counter_reg;
	logic [WORD_W-1:0] pair_q, word_q, sum_q, oper_q, op_val, sum;
	logic [WORD_W-1:0] w [3];
	logic [51:0] note_q [$];
	logic [51:0] seen, exp;
	logic [31:0] seed = 32'hE628;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	ops_panel_sequencer dut_u (.clock(clock), .rst(rst), .panel_sw(panel_sw),
		.counter_switches(counter_switches), .tape_in(tape_in), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .ctl_in(ctl_in), .operand_wr_en(operand_wr_en),
		.operand_wr_data(operand_wr_data), .mem_out(mem_out), .exec_out(exec_out),
		.gate_left_reg(gate_left_reg), .gate_right_reg(gate_right_reg),
		.counter_reg(counter_reg), .instruction_pair_register(pair_q),
		.reader_word_register(word_q), .load_checksum_accumulator(sum_q),
		.preserved_operand_register(oper_q), .bp_halt_reg(bp_halt_reg),
		.running_reg(running_reg));

	ops_far_model far_u (.clock(clock), .rst(rst), .mem_out(mem_out), .exec_out(exec_out),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .ctl_in(ctl_in));

	// Free-running clock
	always #5 clock = ~clock;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task check(input logic [51:0] got, input logic [51:0] want);
		samples_checked++;
		if (got !== want)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, got, want);
		end
	endtask

	task final_report;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Button held long enough for the synchroniser to see one edge
	task press(input int b);
		@(negedge clock);
		panel_sw[b] = 1'b1;
		repeat (8) @(negedge clock);
		panel_sw[b] = 1'b0;
	endtask

	task go(input int b);
		int n;
		n = 0;
		press(b);
		while (running_reg === 1'b1 && n < 500)
		begin
			@(negedge clock);
			n++;
		end
		repeat (4) @(negedge clock);
	endtask

	task exec_note(input logic [HALF_W-1:0] i);
		note_q.push_back({2'b10, 30'h0, i});
	endtask

	// Idle reader lines show inverted data, not the last delivery
	task tape(input logic sp, input logic [WORD_W-1:0] d);
		@(negedge clock);
		tape_in = {1'b1, sp, d};
		@(negedge clock);
		tape_in = {1'b0, ~sp, ~d};
		@(negedge clock);
	endtask

	task panel(input logic [ADDR_W-1:0] ctr, input logic [1:0] gates);
		check({40'h0, counter_reg, gate_left_reg, gate_right_reg}, {40'h0, ctr, gates});
	endtask

	// Every execute or memory write must match the oldest note
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			final_report();
		end
		if (!rst && (exec_out.req || mem_out.wr_en))
		begin
			seen = exec_out.req ? {2'b10, 30'h0, exec_out.instr}
				: {2'b01, mem_out.addr, mem_out.wr_data};
			exp = note_q.size() != 0 ? note_q.pop_front() : ~seen;
			check(seen, exp);
		end
	end

	// Main sequence
	initial
	begin
		repeat (4) @(negedge clock);
		rst = 0;
		panel(10'h000, 2'b01);
		for (int i = 0; i < 3; i++)
			w[i] = WORD_W'({xs(), xs()}) | 40'h8800088000;
		w[1][39] = 1'b0;
		sum = w[0] + w[1] + w[2];
		op_val = WORD_W'({xs(), xs()});
		operand_wr_data = op_val;
		operand_wr_en = 1;
		@(negedge clock);
		operand_wr_en = 0;
		counter_switches = 10'h3FE;
		go(SW_SETCTR);
		panel(10'h3FE, 2'b01);
		$display("test set counter done");
		panel_sw[SW_LOAD] = 1'b1;
		repeat (10) @(negedge clock);
		operand_wr_data = ~op_val;
		operand_wr_en = 1;
		@(negedge clock);
		operand_wr_en = 0;
		for (int i = 0; i < 3; i++)
		begin
			note_q.push_back({2'b01, 10'(10'h3FE + i), w[i]});
			tape(1'b0, w[i]);
		end
		tape(1'b1, '0);
		tape(1'b1, '0);
		repeat (6) @(negedge clock);
		check(52'(sum_q), 52'(sum));
		check(52'(word_q), 52'(w[2]));
		check(52'(pair_q), 52'h0);
		check(52'(oper_q), 52'(op_val));
		panel(10'h3FE, 2'b01);
		press(SW_START);
		repeat (10) @(negedge clock);
		panel_sw[SW_LOAD] = 1'b0;
		repeat (10) @(negedge clock);
		$display("test load done");
		exec_note(w[0][39:20]);
		go(SW_START);
		panel(10'h3FF, 2'b10);
		exec_note(w[0][19:0]);
		go(SW_START);
		panel(10'h3FF, 2'b01);
		exec_note(w[0][19:0]);
		go(SW_PERFORM);
		panel(10'h3FF, 2'b01);
		$display("test manual stepping done");
		panel_sw[SW_RED] = 1'b1;
		go(SW_START);
		check(52'(bp_halt_reg), 52'h1);
		panel(10'h000, 2'b10);
		exec_note(w[1][19:0]);
		go(SW_START);
		panel(10'h000, 2'b01);
		$display("test red breakpoint done");
		panel_sw[SW_AUTO] = 1'b1;
		exec_note(w[2][39:20]);
		exec_note(w[2][19:0]);
		go(SW_START);
		check(52'(bp_halt_reg), 52'h1);
		panel(10'h002, 2'b10);
		panel_sw[SW_RED] = 1'b0;
		panel_sw[SW_GREEN] = 1'b1;
		// Zero order transfers to the right half at 3FE, then runs on
		exec_note(20'h0);
		exec_note(w[0][19:0]);
		exec_note(w[1][39:20]);
		exec_note(w[1][19:0]);
		exec_note(w[2][39:20]);
		exec_note(w[2][19:0]);
		go(SW_PERFORM);
		check(52'(bp_halt_reg), 52'h1);
		panel(10'h002, 2'b10);
		check(52'(note_q.size()), 52'h0);
		$display("test automatic run done");
		// Empty reload with the left gate lit, then start only flips gates
		panel_sw[SW_LOAD] = 1'b1;
		repeat (10) @(negedge clock);
		tape(1'b1, '0);
		tape(1'b1, '0);
		panel_sw[SW_LOAD] = 1'b0;
		repeat (10) @(negedge clock);
		check(52'(sum_q), 52'h0);
		check(52'(word_q), 52'h0);
		go(SW_START);
		panel(10'h002, 2'b01);
		check(52'(pair_q), 52'h0);
		check(52'(note_q.size()), 52'h0);
		$display("test reload start done");
		final_report();
	end
endmodule
